/* File: exec_alu.sv */
`timescale 1ns/1ps
`include "exec_defs.svh"

// Eight-bit data path, purely combinational
module exec_alu
   import exec_pkg::*;
(
   // Operation and operands
   input  wire op_e        op,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] mem,
   input  wire logic [7:0] imm,
   input  wire logic       imm_sel,
   input  wire logic [2:0] bit_sel,
   input  wire logic       carry_in,
   // Results
   output logic [7:0]      result,
   output logic            carry_out,
   output logic            aux_out,
   output logic            ovf_out,
   output logic            flag_z_upd,
   output logic            flag_c_upd,
   output logic            flag_aov_upd
);

   wire [7:0] opnd     = imm_sel ? imm : mem;
   wire       use_c    = (op == OP_ADC) || (op == OP_SBC);
   wire       cin      = use_c ? carry_in : 1'b0;
   wire       is_sub   = (op == OP_SUB) || (op == OP_SBC);
   // Subtract as add of complement; carry set means no borrow
   wire [7:0] addend   = is_sub ? ~opnd : opnd;
   wire       cin_eff  = is_sub ? (use_c ? carry_in : 1'b1) : cin;
   wire [8:0] sum      = {1'b0, acc} + {1'b0, addend} + {8'h00, cin_eff};
   wire [4:0] low_sum  = {1'b0, acc[3:0]} + {1'b0, addend[3:0]}
                         + {4'h0, cin_eff};
   wire [7:0] bit_mask = 8'h01 << bit_sel;
   wire       is_arith = (op == OP_ADD) || (op == OP_ADC) || is_sub;
   wire       is_logic = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR)
                         || (op == OP_CPL);
   wire       is_incd  = (op == OP_INC) || (op == OP_DEC);

   always_comb begin
      result    = opnd;
      carry_out = carry_in;
      unique case (op)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
            result    = sum[7:0];
            carry_out = sum[8];
         end
         OP_AND:     result = acc & opnd;
         OP_OR:      result = acc | opnd;
         OP_XOR:     result = acc ^ opnd;
         OP_CPL:     result = ~mem;
         OP_INC:     result = mem + 8'h01;
         OP_DEC:     result = mem - 8'h01;
         OP_RR:      result = {mem[0], mem[7:1]};
         OP_RL:      result = {mem[6:0], mem[7]};
         OP_RRC: begin
            result    = {carry_in, mem[7:1]};
            carry_out = mem[0];
         end
         OP_RLC: begin
            result    = {mem[6:0], carry_in};
            carry_out = mem[7];
         end
         OP_SET_BIT: result = mem | bit_mask;
         OP_CLR_BIT: result = mem & ~bit_mask;
         OP_MOV_AM:  result = acc;
         default:    result = opnd;
      endcase
   end

   assign aux_out      = low_sum[4];
   assign ovf_out      = (acc[7] == addend[7]) && (sum[7] != acc[7]);
   assign flag_z_upd   = is_arith || is_logic || is_incd;
   assign flag_c_upd   = is_arith || (op == OP_RRC) || (op == OP_RLC);
   assign flag_aov_upd = is_arith;

endmodule

/* File: exec_ctrl.sv */
`timescale 1ns/1ps
`include "exec_defs.svh"

module exec_ctrl
   import exec_pkg::*;
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   // Decoded instruction, held steady by the fetch logic
   input  wire op_e                 instr_op,
   input  wire logic                instr_to_mem,
   input  wire logic                instr_imm_sel,
   input  wire logic [7:0]          instr_imm,
   input  wire logic [2:0]          instr_bit,
   input  wire logic                instr_dst_pcl,
   input  wire logic [`PC_W-1:0]    instr_target,
   // Data memory and table read data
   input  wire logic [7:0]          mem_rdata,
   input  wire logic [7:0]          table_rdata,
   // Wake request out of power-down
   input  wire logic                wake_req,
   // Sequencing and results
   output logic [`PC_W-1:0]         pc_q,
   output logic                     icyc_start_q,
   output logic                     exec_valid_q,
   output logic [7:0]               acc_q,
   output logic [3:0]               flags_q,
   output logic                     global_interrupt_enable_q,
   output logic                     mem_we_q,
   output logic [7:0]               mem_wdata_q,
   output logic                     table_valid_q,
   output logic                     power_down_q,
   output logic                     wdt_clear_q
);

   logic [1:0]       phase_q;
   seq_e             seq_q;
   seq_e             seq_d;
   logic             skip_q;
   logic [`PC_W-1:0] stack_q [`STACK_DEPTH];
   logic [1:0]       sp_q;

   logic [7:0] alu_res;
   logic       alu_c;
   logic       alu_ac;
   logic       alu_ov;
   logic       upd_z;
   logic       upd_c;
   logic       upd_aov;

   exec_alu u_alu (
      .op           (instr_op),
      .acc          (acc_q),
      .mem          (mem_rdata),
      .imm          (instr_imm),
      .imm_sel      (instr_imm_sel),
      .bit_sel      (instr_bit),
      .carry_in     (flags_q[`FLAG_C]),
      .result       (alu_res),
      .carry_out    (alu_c),
      .aux_out      (alu_ac),
      .ovf_out      (alu_ov),
      .flag_z_upd   (upd_z),
      .flag_c_upd   (upd_c),
      .flag_aov_upd (upd_aov)
   );

   // Execution happens on the last system clock of the instruction cycle
   wire last_phase = (phase_q == (`CLKS_PER_ICYC - 3'h1));
   wire do_exec    = last_phase && (seq_q == ST_EXEC) && !skip_q;
   wire squash     = last_phase && (seq_q == ST_EXEC) && skip_q;

   wire is_skip    = (instr_op == OP_SZ) || (instr_op == OP_SNZ)
                     || (instr_op == OP_SZ_BIT) || (instr_op == OP_SNZ_BIT);
   wire test_bit   = mem_rdata[instr_bit];
   wire skip_hit   = ((instr_op == OP_SZ) && (mem_rdata == 8'h00))
                     || ((instr_op == OP_SNZ) && (mem_rdata != 8'h00))
                     || ((instr_op == OP_SZ_BIT) && !test_bit)
                     || ((instr_op == OP_SNZ_BIT) && test_bit);
   wire is_flow    = (instr_op == OP_JUMP) || (instr_op == OP_CALL)
                     || (instr_op == OP_RET) || (instr_op == OP_RETURN_FROM_INTERRUPT)
                     || (instr_op == OP_TABRD);
   wire mem_write  = instr_to_mem || (instr_op == OP_MOV_AM)
                     || (instr_op == OP_SET_BIT) || (instr_op == OP_CLR_BIT)
                     || (instr_op == OP_CPL && instr_to_mem);
   wire pcl_write  = mem_write && instr_dst_pcl;
   wire acc_write  = !mem_write && !is_skip && !is_flow
                     && (instr_op != OP_NOP) && (instr_op != OP_HALT)
                     && (instr_op != OP_WDT_CLR);
   wire need_extra = is_flow || pcl_write;
   wire [`PC_W-1:0] pc_next  = pc_q + `PC_W'(1);
   wire [`PC_W-1:0] pcl_addr = {pc_q[`PC_W-1:8], alu_res};
   wire [1:0]       sp_dec   = sp_q - 2'h1;

   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         ST_EXEC: begin
            if (do_exec && instr_op == OP_HALT)
               seq_d = ST_HALT;
            else if (do_exec && need_extra)
               seq_d = ST_EXTRA;
         end
         ST_EXTRA: begin
            if (last_phase)
               seq_d = ST_EXEC;
         end
         ST_HALT: begin
            if (wake_req)
               seq_d = ST_EXEC;
         end
         default: seq_d = ST_EXEC;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase_q      <= 2'h0;
         seq_q        <= ST_EXEC;
         icyc_start_q <= 1'b0;
      end else begin
         phase_q      <= (seq_q == ST_HALT) ? 2'h0 : phase_q + 2'h1;
         seq_q        <= seq_d;
         icyc_start_q <= (seq_q != ST_HALT) && last_phase;
      end
   end

   // Program counter, stack and skip
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pc_q   <= `PC_RST;
         skip_q <= 1'b0;
         sp_q   <= 2'h0;
         global_interrupt_enable_q <= `GIE_RST;
      end else if (squash) begin
         pc_q   <= pc_next;
         skip_q <= 1'b0;
      end else if (do_exec) begin
         skip_q <= is_skip && skip_hit;
         unique case (instr_op)
            OP_JUMP: pc_q <= instr_target;
            OP_CALL: begin
               pc_q <= instr_target;
               sp_q <= sp_q + 2'h1;
            end
            OP_RET: begin
               pc_q <= stack_q[sp_dec];
               sp_q <= sp_dec;
            end
            OP_RETURN_FROM_INTERRUPT: begin
               pc_q <= stack_q[sp_dec];
               sp_q <= sp_dec;
               global_interrupt_enable_q <= 1'b1;
            end
            default: pc_q <= pcl_write ? pcl_addr : pc_next;
         endcase
      end
   end

   // Stack wraps silently on overflow, as a small hardware stack does
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `STACK_DEPTH; i++)
            stack_q[i] <= `PC_RST;
      end else if (do_exec && instr_op == OP_CALL) begin
         stack_q[sp_q] <= pc_next;
      end
   end

   // Accumulator, flags and memory write
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         acc_q         <= `ACC_RST;
         flags_q       <= `FLAGS_RST;
         mem_we_q      <= 1'b0;
         mem_wdata_q   <= 8'h00;
         table_valid_q <= 1'b0;
         wdt_clear_q   <= 1'b0;
         exec_valid_q  <= 1'b0;
      end else begin
         mem_we_q      <= do_exec && mem_write;
         table_valid_q <= do_exec && instr_op == OP_TABRD;
         wdt_clear_q   <= do_exec && instr_op == OP_WDT_CLR;
         exec_valid_q  <= do_exec;
         if (do_exec && mem_write)
            mem_wdata_q <= alu_res;
         if (do_exec && instr_op == OP_TABRD)
            acc_q <= table_rdata;
         else if (do_exec && acc_write)
            acc_q <= alu_res;
         if (do_exec) begin
            if (upd_z)
               flags_q[`FLAG_Z] <= (alu_res == 8'h00);
            if (upd_c)
               flags_q[`FLAG_C] <= alu_c;
            if (upd_aov) begin
               flags_q[`FLAG_AC] <= alu_ac;
               flags_q[`FLAG_OV] <= alu_ov;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         power_down_q <= 1'b0;
      else
         power_down_q <= (seq_d == ST_HALT);
   end

   // Execution strobes are at least four clocks apart
   exec_spacing_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      exec_valid_q |=> !exec_valid_q [*3])
      else $error("execution strobes closer than one cycle");
   // Jump adds a full extra instruction cycle
   jump_extra_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_JUMP) |=> !do_exec [*7])
      else $error("jump did not take two cycles");
   jump_target_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_JUMP) |=> pc_q == $past(instr_target))
      else $error("jump target not loaded");
   call_return_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_CALL) |=> stack_q[$past(sp_q)]
         == $past(pc_next))
      else $error("call did not save return address");
   return_from_interrupt_enable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_RETURN_FROM_INTERRUPT) |=> global_interrupt_enable_q)
      else $error("interrupt return left enable low");
   skip_squash_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && is_skip && skip_hit) |=> ##3 squash)
      else $error("taken skip did not squash next");
   zero_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && upd_z) |=> flags_q[`FLAG_Z] == ($past(alu_res) == 8'h00))
      else $error("zero flag wrong");
   bit_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_SET_BIT) |=> mem_we_q
         && mem_wdata_q == ($past(mem_rdata) | (8'h01 << $past(instr_bit))))
      else $error("bit set touched other bits");
   halt_down_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_HALT) |=> power_down_q)
      else $error("halt did not power down");
   // Low byte write lands the result and costs a whole extra cycle
   pcl_jump_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && pcl_write) |=> pc_q[7:0] == $past(alu_res))
      else $error("low byte write did not jump");
   pcl_extra_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && pcl_write) |=> !do_exec [*7])
      else $error("low byte write did not take two cycles");
   flow_extra_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && is_flow) |=> !do_exec [*7])
      else $error("flow instruction did not take two cycles");
   // Carry is recomputed here from the operands, not taken from the ALU
   add_carry_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_ADD && !instr_imm_sel)
      |=> flags_q[`FLAG_C]
         == $past((9'(acc_q) + 9'(mem_rdata)) > 9'h0FF))
      else $error("add carry wrong");
   squash_pc_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      squash |=> !exec_valid_q && pc_q == $past(pc_q) + 11'h001)
      else $error("squashed slot misbehaved");
   table_acc_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_TABRD)
      |=> table_valid_q && acc_q == $past(table_rdata))
      else $error("table data not delivered");
   ret_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_RET)
      |=> $stable(global_interrupt_enable_q))
      else $error("plain return touched global enable");
   halt_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (power_down_q && $past(power_down_q)) |-> !exec_valid_q)
      else $error("execution while powered down");
   move_imm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (do_exec && instr_op == OP_MOV_XA && instr_imm_sel)
      |=> acc_q == $past(instr_imm))
      else $error("immediate move wrong");

endmodule

/* File: exec_defs.svh */
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// System clocks per instruction cycle
`define CLKS_PER_ICYC     3'h4
// Program counter width
`define PC_W              11
// Status bit positions in the flags output
`define FLAG_Z            0
`define FLAG_C            1
`define FLAG_AC           2
`define FLAG_OV           3
// Reset values
`define PC_RST            11'h000
`define ACC_RST           8'h00
`define FLAGS_RST         4'h0
`define GIE_RST           1'b0
// Stack depth of saved return addresses
`define STACK_DEPTH       4

`endif

/* File: exec_pkg.sv */
package exec_pkg;

   // Operation requested for the current instruction
   typedef enum logic [4:0] {
      OP_NOP      = 5'h00,
      OP_MOV_MA   = 5'h01,
      OP_MOV_AM   = 5'h02,
      OP_MOV_XA   = 5'h03,
      OP_ADD      = 5'h04,
      OP_ADC      = 5'h05,
      OP_SUB      = 5'h06,
      OP_SBC      = 5'h07,
      OP_AND      = 5'h08,
      OP_OR       = 5'h09,
      OP_XOR      = 5'h0A,
      OP_CPL      = 5'h0B,
      OP_INC      = 5'h0C,
      OP_DEC      = 5'h0D,
      OP_RR       = 5'h0E,
      OP_RL       = 5'h0F,
      OP_RRC      = 5'h10,
      OP_RLC      = 5'h11,
      OP_SZ       = 5'h12,
      OP_SNZ      = 5'h13,
      OP_SZ_BIT   = 5'h14,
      OP_SNZ_BIT  = 5'h15,
      OP_SET_BIT  = 5'h16,
      OP_CLR_BIT  = 5'h17,
      OP_JUMP     = 5'h18,
      OP_CALL     = 5'h19,
      OP_RET      = 5'h1A,
      OP_RETURN_FROM_INTERRUPT     = 5'h1B,
      OP_TABRD    = 5'h1C,
      OP_HALT     = 5'h1D,
      OP_WDT_CLR  = 5'h1E
   } op_e;

   // Instruction cycle sequencing
   typedef enum logic [1:0] {
      ST_EXEC  = 2'b00,
      ST_EXTRA = 2'b01,
      ST_HALT  = 2'b10
   } seq_e;

endpackage

/* File: tb_mcu_instruction_execution_control.sv */
`timescale 1ns/1ps
`include "exec_defs.svh"

module tb_mcu_instruction_execution_control;
   import exec_pkg::*;

   logic             ref_clk;
   logic             rstn;
   op_e              instr_op;
   logic             instr_to_mem;
   logic             instr_imm_sel;
   logic [7:0]       instr_imm;
   logic [2:0]       instr_bit;
   logic             instr_dst_pcl;
   logic [`PC_W-1:0] instr_target;
   logic [7:0]       mem_rdata;
   logic [7:0]       table_rdata;
   logic             wake_req;
   logic [`PC_W-1:0] pc_q;
   logic             icyc_start_q;
   logic             exec_valid_q;
   logic [7:0]       acc_q;
   logic [3:0]       flags_q;
   logic             global_interrupt_enable_q;
   logic             mem_we_q;
   logic [7:0]       mem_wdata_q;
   logic             table_valid_q;
   logic             power_down_q;
   logic             wdt_clear_q;
   int               fail_count;
   int               check_count;
   logic [`PC_W-1:0] p;
   logic [7:0]       a;
   logic [7:0]       e;
   logic             seen;
   op_e              lop[4];
   logic [7:0]       lv[4];

   exec_ctrl dut (
      .ref_clk                   (ref_clk),
      .rstn                      (rstn),
      .instr_op                  (instr_op),
      .instr_to_mem              (instr_to_mem),
      .instr_imm_sel             (instr_imm_sel),
      .instr_imm                 (instr_imm),
      .instr_bit                 (instr_bit),
      .instr_dst_pcl             (instr_dst_pcl),
      .instr_target              (instr_target),
      .mem_rdata                 (mem_rdata),
      .table_rdata               (table_rdata),
      .wake_req                  (wake_req),
      .pc_q                      (pc_q),
      .icyc_start_q              (icyc_start_q),
      .exec_valid_q              (exec_valid_q),
      .acc_q                     (acc_q),
      .flags_q                   (flags_q),
      .global_interrupt_enable_q (global_interrupt_enable_q),
      .mem_we_q                  (mem_we_q),
      .mem_wdata_q               (mem_wdata_q),
      .table_valid_q             (table_valid_q),
      .power_down_q              (power_down_q),
      .wdt_clear_q               (wdt_clear_q)
   );

   always #50 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Operand goes to both immediate and memory so the select is exercised
   // without changing the expected value
   task automatic ex(input op_e o, input logic m, input logic [7:0] v,
                     input logic [2:0] b, input int gap,
                     input logic [`PC_W-1:0] npc);
      int n;
      instr_op = o;
      instr_to_mem = m;
      instr_imm = v;
      mem_rdata = v;
      instr_bit = b;
      instr_imm_sel = ~instr_imm_sel;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (exec_valid_q !== 1'b1 && n < 40);
      if (gap > 0)
         chk(n, gap);
      chk(icyc_start_q, 1);
      chk(pc_q, npc);
      p = npc;
   endtask

   // Slot after a taken skip: must not execute
   task automatic sq();
      instr_op = OP_MOV_XA;
      instr_imm = 8'hEE;
      seen = 1'b0;
      repeat (4) begin
         @(negedge ref_clk);
         seen |= exec_valid_q;
      end
      chk(seen, 0);
      p = p + 1'b1;
   endtask

   initial begin
      repeat (3000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end

   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      instr_op = OP_NOP;
      instr_to_mem = 1'b0;
      instr_imm_sel = 1'b0;
      instr_imm = 8'h00;
      instr_bit = 3'h0;
      instr_dst_pcl = 1'b0;
      instr_target = 11'h000;
      mem_rdata = 8'h00;
      table_rdata = 8'h00;
      wake_req = 1'b0;
      fail_count = 0;
      check_count = 0;
      lop = '{OP_AND, OP_OR, OP_XOR, OP_CPL};
      lv = '{8'h0F, 8'h00, 8'hF0, 8'hFF};
      repeat (12) @(negedge ref_clk);
      chk({pc_q, acc_q, flags_q, global_interrupt_enable_q}, 0);
      rstn = 1'b1;
      p = 11'h000;
      ex(OP_MOV_XA, 0, 8'h80, 0, 4, p + 1'b1);
      chk(acc_q, 8'h80);
      ex(OP_ADD, 0, 8'h80, 0, 4, p + 1'b1);
      chk({acc_q, flags_q}, 12'h00B);
      ex(OP_MOV_XA, 0, 8'h0F, 0, 4, p + 1'b1);
      ex(OP_ADD, 0, 8'h01, 0, 4, p + 1'b1);
      chk({acc_q, flags_q}, 12'h104);
      ex(OP_SUB, 0, 8'h11, 0, 4, p + 1'b1);
      chk({acc_q, flags_q[1:0]}, 10'h3FC);
      ex(OP_SUB, 0, 8'h01, 0, 4, p + 1'b1);
      chk({acc_q, flags_q[1:0]}, 10'h3FA);
      ex(OP_MOV_AM, 1, 8'h00, 0, 4, p + 1'b1);
      chk({mem_we_q, mem_wdata_q, acc_q}, 17'h1FEFE);
      ex(OP_MOV_MA, 0, 8'h5A, 0, 4, p + 1'b1);
      chk({mem_we_q, acc_q}, 9'h05A);
      ex(OP_INC, 1, 8'hFF, 0, 4, p + 1'b1);
      chk({mem_we_q, mem_wdata_q, acc_q, flags_q[0]}, 18'h200B5);
      ex(OP_INC, 0, 8'h41, 0, 4, p + 1'b1);
      chk({acc_q, flags_q[0]}, 9'h084);
      ex(OP_DEC, 0, 8'h00, 0, 4, p + 1'b1);
      chk(acc_q, 8'hFF);
      ex(OP_DEC, 1, 8'h01, 0, 4, p + 1'b1);
      chk({mem_we_q, mem_wdata_q, flags_q[0]}, 10'h201);
      for (int i = 0; i < 4; i++) begin
         a = 8'hF0;
         ex(OP_MOV_XA, 0, a, 0, 4, p + 1'b1);
         ex(lop[i], 0, lv[i], 0, 4, p + 1'b1);
         case (lop[i])
            OP_AND: e = a & lv[i];
            OP_OR:  e = a | lv[i];
            OP_XOR: e = a ^ lv[i];
            default: e = ~lv[i];
         endcase
         chk({acc_q, flags_q[0]}, {e, e == 8'h00});
      end
      ex(OP_MOV_XA, 0, 8'h00, 0, 4, p + 1'b1);
      ex(OP_ADD, 0, 8'h00, 0, 4, p + 1'b1);
      ex(OP_RL, 0, 8'h81, 0, 4, p + 1'b1);
      chk(acc_q, 8'h03);
      ex(OP_RR, 0, 8'h81, 0, 4, p + 1'b1);
      chk(acc_q, 8'hC0);
      ex(OP_RLC, 0, 8'h81, 0, 4, p + 1'b1);
      chk({acc_q, flags_q[1]}, 9'h005);
      ex(OP_RRC, 0, 8'h02, 0, 4, p + 1'b1);
      chk({acc_q, flags_q[1]}, 9'h102);
      ex(OP_SET_BIT, 1, 8'h00, 7, 4, p + 1'b1);
      chk({mem_we_q, mem_wdata_q}, 9'h180);
      ex(OP_CLR_BIT, 1, 8'hFF, 0, 4, p + 1'b1);
      chk({mem_we_q, mem_wdata_q}, 9'h1FE);
      // Skips: taken ones cost the squashed slot, others do not
      ex(OP_SZ, 0, 8'h00, 0, 4, p + 1'b1);
      sq();
      ex(OP_SNZ, 0, 8'h00, 0, 4, p + 1'b1);
      ex(OP_SZ, 0, 8'h01, 0, 4, p + 1'b1);
      ex(OP_SZ_BIT, 0, 8'hF7, 3, 4, p + 1'b1);
      sq();
      ex(OP_SNZ_BIT, 0, 8'h08, 3, 4, p + 1'b1);
      sq();
      ex(OP_NOP, 0, 8'h00, 0, 4, p + 1'b1);
      chk(acc_q, 8'h81);
      instr_target = 11'h123;
      ex(OP_JUMP, 0, 8'h00, 0, 4, 11'h123);
      ex(OP_NOP, 0, 8'h00, 0, 8, 11'h124);
      instr_target = 11'h200;
      ex(OP_CALL, 0, 8'h00, 0, 4, 11'h200);
      ex(OP_NOP, 0, 8'h00, 0, 8, 11'h201);
      ex(OP_RET, 0, 8'h00, 0, 4, 11'h125);
      chk(global_interrupt_enable_q, 0);
      ex(OP_NOP, 0, 8'h00, 0, 8, 11'h126);
      instr_target = 11'h300;
      ex(OP_CALL, 0, 8'h00, 0, 4, 11'h300);
      ex(OP_RETURN_FROM_INTERRUPT, 0, 8'h00, 0, 8, 11'h127);
      chk(global_interrupt_enable_q, 1);
      ex(OP_NOP, 0, 8'h00, 0, 8, 11'h128);
      ex(OP_MOV_XA, 0, 8'h40, 0, 4, p + 1'b1);
      instr_dst_pcl = 1'b1;
      ex(OP_MOV_AM, 1, 8'h00, 0, 4, {p[10:8], 8'h40});
      instr_dst_pcl = 1'b0;
      ex(OP_NOP, 0, 8'h00, 0, 8, p + 1'b1);
      table_rdata = 8'h3C;
      ex(OP_TABRD, 0, 8'h00, 0, 4, p + 1'b1);
      chk(table_valid_q, 1);
      ex(OP_NOP, 0, 8'h00, 0, 8, p + 1'b1);
      chk(acc_q, 8'h3C);
      ex(OP_WDT_CLR, 0, 8'h00, 0, 4, p + 1'b1);
      chk(wdt_clear_q, 1);
      ex(OP_HALT, 0, 8'h00, 0, 4, p + 1'b1);
      chk(power_down_q, 1);
      // Nothing may execute while powered down
      instr_op = OP_NOP;
      seen = 1'b0;
      repeat (16) begin
         @(negedge ref_clk);
         seen |= exec_valid_q;
      end
      chk({seen, power_down_q}, 2'b01);
      wake_req = 1'b1;
      ex(OP_NOP, 0, 8'h00, 0, 0, p + 1'b1);
      wake_req = 1'b0;
      chk(power_down_q, 0);
      finish_test();
   end
endmodule
